// *** inc/dps_pkg.sv ***
// package for the parallel-input converter front end with power-down
package dps_pkg;
   localparam int unsigned DATA_W         = 12;
   localparam int unsigned DATA_MSB_POS   = 11;
   localparam int unsigned DATA_LSB_POS   = 0;
   localparam logic [11:0] CODE_ZERO      = 12'h000;
   localparam logic [11:0] CODE_FULL      = 12'hfff;
   localparam int unsigned CLK_HZ         = 20000000;
   localparam int unsigned MAX_RATE_MSPS  = 125;
   localparam int unsigned PD_ENTER_NS    = 5000;
   localparam int unsigned PD_EXIT_US     = 3250;
   localparam int unsigned PD_ENTER_CYC   = (PD_ENTER_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int unsigned PD_EXIT_CYC    = PD_EXIT_US * (CLK_HZ / 1000000);
   localparam int unsigned CNT_W          = 17;
   localparam logic [16:0] CNT_ZERO       = 17'h00000;
   localparam logic [16:0] CNT_ONE        = 17'h00001;

   typedef enum logic [1:0] {
      DPS_RUN   = 2'b00,
      DPS_DOWN  = 2'b01,
      DPS_SLEEP = 2'b11,
      DPS_WAKE  = 2'b10
   } dps_state_t;

   typedef struct packed {
      logic [11:0] primary;
      logic [11:0] complement;
   } dps_out_t;
endpackage : dps_pkg

// *** rtl/dps_core.sv ***
// converter front end: sample latch, complementary outputs, power-down sequencing
// Contract
// - twelve-bit straight binary, top line is msb
// - all ones gives full primary current
// - complement output carries inverse of code
// - latch word on rising clock edge only
// - at most 125 MSPS sample rate
// - power-down high switches output current off
// - pull-down keeps converter enabled when open
// - down under 5 us, up 3.25 ms
`timescale 1ns/10ps
module dps_core
  (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       ce_i,
   input  wire logic [dps_pkg::DATA_W-1:0] data_i,
   input  wire logic                       sleep_i,
   input  wire logic                       sleep_driven_i,
   output logic [dps_pkg::DATA_W-1:0]      primary_current_out_o,
   output logic [dps_pkg::DATA_W-1:0]      complement_current_out_o,
   output logic                            output_enabled_o,
   output logic                            ready_o
  );

   // sleep is a pin: synchronise; an undriven pin reads low (pull-down)
   logic                       sl_meta_q;
   logic                       sl_sync_q;
   logic                       sl_raw;
   logic [dps_pkg::DATA_W-1:0] word_q;
   logic [dps_pkg::DATA_W-1:0] word_d;
   dps_pkg::dps_state_t        st_q;
   dps_pkg::dps_state_t        st_d;
   logic [dps_pkg::CNT_W-1:0]  cnt_q;
   logic [dps_pkg::CNT_W-1:0]  cnt_d;
   dps_pkg::dps_out_t          out_q;
   dps_pkg::dps_out_t          out_d;
   logic                       en_q;
   logic                       en_d;
   logic                       rdy_q;
   logic                       rdy_d;
   // the enter count is the promised power-down limit, so it bounds the check below
   localparam int              DOWN_LIMIT = int'(dps_pkg::PD_ENTER_CYC);

   assign sl_raw = sleep_driven_i & sleep_i;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sl_meta_q <= 1'b0;
         sl_sync_q <= 1'b0;
      end
      else if (ce_i)
      begin
         sl_meta_q <= sl_raw;
         sl_sync_q <= sl_meta_q;
      end
   end

   // data from same-clock source logic; captured on rising edge only
   always_comb
   begin
      word_d = data_i;
   end

   always_comb
   begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         dps_pkg::DPS_RUN:
         begin
            if (sl_sync_q)
            begin
               st_d  = dps_pkg::DPS_DOWN;
               cnt_d = dps_pkg::CNT_W'(dps_pkg::PD_ENTER_CYC);
            end
         end
         dps_pkg::DPS_DOWN:
         begin
            if (cnt_q > dps_pkg::CNT_ONE)
               cnt_d = cnt_q - dps_pkg::CNT_ONE;
            else
            begin
               cnt_d = dps_pkg::CNT_ZERO;
               st_d  = dps_pkg::DPS_SLEEP;
            end
         end
         dps_pkg::DPS_SLEEP:
         begin
            if (!sl_sync_q)
            begin
               st_d  = dps_pkg::DPS_WAKE;
               cnt_d = dps_pkg::CNT_W'(dps_pkg::PD_EXIT_CYC);
            end
         end
         dps_pkg::DPS_WAKE:
         begin
            if (sl_sync_q)
            begin
               st_d  = dps_pkg::DPS_SLEEP;
               cnt_d = dps_pkg::CNT_ZERO;
            end
            else if (cnt_q > dps_pkg::CNT_ONE)
               cnt_d = cnt_q - dps_pkg::CNT_ONE;
            else
            begin
               cnt_d = dps_pkg::CNT_ZERO;
               st_d  = dps_pkg::DPS_RUN;
            end
         end
         default:
         begin
            st_d  = dps_pkg::DPS_RUN;
            cnt_d = dps_pkg::CNT_ZERO;
         end
      endcase
   end

   // output current is cut as soon as sleep is seen; the slow analog ramp is not modelled
   always_comb
   begin
      en_d  = (st_d == dps_pkg::DPS_RUN) || (st_d == dps_pkg::DPS_WAKE);
      if (sl_sync_q)
         en_d = 1'b0;
      rdy_d = (st_d == dps_pkg::DPS_RUN);
      if (en_d)
      begin
         out_d.primary    = word_q;
         out_d.complement = ~word_q;
      end
      else
      begin
         out_d.primary    = dps_pkg::CODE_ZERO;
         out_d.complement = dps_pkg::CODE_ZERO;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         word_q <= dps_pkg::CODE_ZERO;
         st_q   <= dps_pkg::DPS_RUN;
         cnt_q  <= dps_pkg::CNT_ZERO;
         out_q  <= '0;
         en_q   <= 1'b0;
         rdy_q  <= 1'b0;
      end
      else if (ce_i)
      begin
         word_q <= word_d;
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         out_q  <= out_d;
         en_q   <= en_d;
         rdy_q  <= rdy_d;
      end
   end

   assign primary_current_out_o    = out_q.primary;
   assign complement_current_out_o = out_q.complement;
   assign output_enabled_o         = en_q;
   assign ready_o                  = rdy_q;

   // power-down entry is two steps: last run cycle, then first down cycle
   sequence s_down_entry;
      st_q == dps_pkg::DPS_RUN ##1 st_q == dps_pkg::DPS_DOWN;
   endsequence

   // an open pin has to pass both synchroniser stages before it counts
   sequence s_pin_open;
      ce_i && !sleep_driven_i ##1 ce_i;
   endsequence

   sequence s_wake_start;
      ce_i && $fell(sl_sync_q) && st_q == dps_pkg::DPS_SLEEP;
   endsequence

   sequence s_wake_abort;
      ce_i && st_q == dps_pkg::DPS_WAKE && sl_sync_q;
   endsequence

   sequence s_wake_last;
      ce_i && st_q == dps_pkg::DPS_WAKE && !sl_sync_q && cnt_q == dps_pkg::CNT_ONE;
   endsequence

   AST_FULL_SCALE: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && en_d && word_q == dps_pkg::CODE_FULL ##1 1'b1 |-> primary_current_out_o == dps_pkg::CODE_FULL)
      else $error("full code not on primary");
   AST_COMPLEMENT: assert property (@(posedge clk_i) disable iff (rst_i)
      output_enabled_o |-> (primary_current_out_o ^ complement_current_out_o) == dps_pkg::CODE_FULL)
      else $error("outputs not complementary");
   AST_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> word_q == $past(data_i))
      else $error("word not latched on edge");
   AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && en_d |=> primary_current_out_o == $past(word_q))
      else $error("output not the latched code");
   AST_SLEEP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && sl_sync_q |=> !output_enabled_o && primary_current_out_o == dps_pkg::CODE_ZERO)
      else $error("current not off in sleep");
   AST_RUN_ON: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && st_q == dps_pkg::DPS_RUN && !sl_sync_q |=> output_enabled_o)
      else $error("current off while running");
   AST_PULLDOWN: assert property (@(posedge clk_i) disable iff (rst_i)
      s_pin_open |=> !sl_sync_q)
      else $error("open sleep pin not low");
   AST_DOWN_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
      s_down_entry |-> ##[1:DOWN_LIMIT] st_q != dps_pkg::DPS_DOWN)
      else $error("power-down too slow");
   AST_WAKE_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wake_start |=> st_q == dps_pkg::DPS_WAKE && !ready_o)
      else $error("wake not started");
   AST_WAKE_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wake_start |=> cnt_q == dps_pkg::CNT_W'(dps_pkg::PD_EXIT_CYC))
      else $error("power-up wait not loaded");
   AST_WAKE_BACK: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wake_abort |=> st_q == dps_pkg::DPS_SLEEP && !output_enabled_o)
      else $error("sleep during power-up ignored");
   AST_WAKE_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wake_last |=> st_q == dps_pkg::DPS_RUN && ready_o)
      else $error("power-up wait overran");
   AST_READY: assert property (@(posedge clk_i) disable iff (rst_i)
      ready_o |-> st_q == dps_pkg::DPS_RUN && output_enabled_o)
      else $error("ready outside run");
endmodule // dps_core

// *** verification/dps_src_model.sv ***
// sample source model driving words on the falling clock edge
`timescale 1ns/10ps
module dps_src_model
  (
   input  wire logic        clk_i,
   input  wire logic [11:0] word_i,
   output logic [11:0]      data_o
  );
   // a word changes only at a falling edge, so it is stable at capture
   always @(negedge clk_i)
   begin
      data_o <= word_i;
   end
endmodule // dps_src_model

// *** verification/dac_parallel_input_sleep_tb.sv ***
// self-checking bench for the converter front end
`timescale 1ns/10ps
module dac_parallel_input_sleep_tb;
   logic        clk_i, rst_i, ce_i, sleep_i, sleep_driven_i, chk, oen, rdy;
   logic [11:0] word, data_i, prim, comp, d1, d2;
   logic [11:0] corner [2];
   int          n_errors, cmp_count, i;

   function automatic logic [11:0] lfsr(input logic [11:0] v);
      return {v[10:0], v[11] ^ v[10] ^ v[9] ^ v[3]};
   endfunction
   task automatic chk_word(input string nm, input logic [11:0] e, input logic [11:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic finish_test;
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   initial
   begin
      // budget: the long power-up wait plus margin for everything else
      #((dps_pkg::PD_EXIT_CYC + 15000) * 50);
      n_errors++;
      finish_test();
   end

   dps_src_model src (.clk_i(clk_i), .word_i(word), .data_o(data_i));
   dps_core dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .data_i(data_i), .sleep_i(sleep_i),
                 .sleep_driven_i(sleep_driven_i), .primary_current_out_o(prim),
                 .complement_current_out_o(comp), .output_enabled_o(oen), .ready_o(rdy));

   // expected word runs two enabled edges behind the pins
   always @(posedge clk_i)
   begin
      if (ce_i === 1'b1)
      begin
         d2 = d1;
         d1 = data_i;
      end
      #10;
      if (chk)
      begin
         chk_word("primary", d2, prim);
         chk_word("complement", ~d2, comp);
      end
   end

   initial
   begin
      rst_i          = 1'b1;
      ce_i           = 1'b1;
      sleep_i        = 1'b0;
      sleep_driven_i = 1'b1;
      chk            = 1'b0;
      word           = 12'h01a;
      n_errors       = 0;
      cmp_count      = 0;
      corner[0]      = dps_pkg::CODE_FULL;
      corner[1]      = dps_pkg::CODE_ZERO;
      cyc(5);
      chk_word("reset primary", 12'h000, prim);
      chk_bit("reset ready", 1'b0, rdy);
      rst_i <= 1'b0;
      for (i = 0; i < 20 && rdy !== 1'b1; i++)
         cyc(1);
      chk_bit("ready", 1'b1, rdy);
      cyc(2);
      chk <= 1'b1;
      for (i = 0; i < 2; i++)
      begin
         word <= corner[i];
         cyc(4);
         chk_word("corner primary", corner[i], prim);
         chk_word("corner complement", ~corner[i], comp);
      end
      // word stays zero here (lfsr keeps zero), so clock enable is low on every edge and only the hold between captures is probed
      for (i = 0; i < 2000; i++)
      begin
         word <= lfsr(word);
         ce_i <= word[0] | word[5];
         cyc(1);
      end
      ce_i    <= 1'b1;
      chk     <= 1'b0;
      sleep_i <= 1'b1;
      cyc(6);
      chk_bit("sleep enabled", 1'b0, oen);
      chk_word("sleep primary", 12'h000, prim);
      chk_word("sleep complement", 12'h000, comp);
      cyc(dps_pkg::PD_ENTER_CYC + 10);
      chk_bit("asleep ready", 1'b0, rdy);
      sleep_driven_i <= 1'b0;
      cyc(10);
      chk_bit("wake enabled", 1'b1, oen);
      // a sleep request inside the power-up wait cuts the current again and restarts the wait
      sleep_driven_i <= 1'b1;
      cyc(6);
      chk_bit("rewake sleep enabled", 1'b0, oen);
      chk_word("rewake sleep primary", 12'h000, prim);
      chk_bit("rewake sleep ready", 1'b0, rdy);
      sleep_driven_i <= 1'b0;
      cyc(10);
      chk_bit("rewake enabled", 1'b1, oen);
      cyc(dps_pkg::PD_EXIT_CYC - 30);
      chk_bit("early ready", 1'b0, rdy);
      for (i = 0; i < 60 && rdy !== 1'b1; i++)
         cyc(1);
      chk_bit("wake ready", 1'b1, rdy);
      cyc(2);
      chk <= 1'b1;
      cyc(50);
      rst_i <= 1'b1;
      chk   <= 1'b0;
      cyc(2);
      chk_word("mid reset primary", 12'h000, prim);
      chk_bit("mid reset ready", 1'b0, rdy);
      chk_bit("mid reset enabled", 1'b0, oen);
      rst_i <= 1'b0;
      cyc(5);
      chk_bit("mid reset ready back", 1'b1, rdy);
      chk <= 1'b1;
      cyc(50);
      finish_test();
   end
endmodule // dac_parallel_input_sleep_tb
